// File: hw/async_serial_transceiver.v
// asynchronous serial transceiver with an AXI4-Lite register slave
`include "uart_defs.vh"

module async_serial_transceiver (
  input  wire        clk,
  input  wire        rst,
  input  wire [4:0]  s_axi_awaddr,
  input  wire        s_axi_awvalid,
  output wire        s_axi_awready,
  input  wire [31:0] s_axi_wdata,
  input  wire [3:0]  s_axi_wstrb,
  input  wire        s_axi_wvalid,
  output wire        s_axi_wready,
  output reg  [1:0]  s_axi_bresp,
  output reg         s_axi_bvalid,
  input  wire        s_axi_bready,
  input  wire [4:0]  s_axi_araddr,
  input  wire        s_axi_arvalid,
  output wire        s_axi_arready,
  output reg  [31:0] s_axi_rdata,
  output reg  [1:0]  s_axi_rresp,
  output reg         s_axi_rvalid,
  input  wire        s_axi_rready,
  input  wire        serialInPin,
  output reg         serialOutPin,
  output reg         txIrq,
  output reg         rxIrq,
  output reg         rxErrIrq
);
  localparam S_IDLE = 3'd0, S_START = 3'd1, S_DATA = 3'd2, S_PAR = 3'd3, S_STOP = 3'd4, S_GAP = 3'd5;

  function mapped;
    input [4:0] a;
    begin
      mapped = (a == `ADDR_MODE) || (a == `ADDR_TXBUF) || (a == `ADDR_RXBUF) || (a == `ADDR_TXSTAT) ||
               (a == `ADDR_RXERR) || (a == `ADDR_CTRL) || (a == `ADDR_DIV);
    end
  endfunction

  // parity of the active data bits, even sense
  function parity;
    input [7:0] d;
    input       len8;
    begin
      parity = ^d[6:0] ^ (len8 & d[7]);
    end
  endfunction

  reg [7:0]  lineModeReg_r;
  reg        invert_r;
  reg [15:0] div_r;
  reg [7:0]  txBuffer_r;
  reg        txFull_r;
  reg [7:0]  rxBuffer_r;
  reg        rxFull_r;
  reg [2:0]  rxErr_r;
  reg [4:0]  awAddr_r;
  reg        awHeld_r;
  reg [31:0] wData_r;
  reg        wHeld_r;
  reg [3:0]  wStrb_r;
  reg        rxSync1_r;
  reg        rxSync2_r;
  reg        rxArmed_r;
  reg [2:0]  txState_r;
  reg [15:0] txCnt_r;
  reg [3:0]  txBit_r;
  reg [7:0]  txShift_r;
  reg        txPar_r;
  reg        txLine_r;
  reg [2:0]  rxState_r;
  reg [15:0] rxCnt_r;
  reg [3:0]  rxBit_r;
  reg [7:0]  rxShift_r;
  reg        rxParErr_r;

  wire power   = lineModeReg_r[`B_POWER];
  wire txOn    = power & lineModeReg_r[`B_TXEN];
  wire rxOn    = power & lineModeReg_r[`B_RXEN];
  wire len8    = lineModeReg_r[`B_CHARLEN];
  wire [1:0] parMode = {lineModeReg_r[`B_PARHI], lineModeReg_r[`B_PARLO]};
  wire [3:0] nBits   = len8 ? 4'h8 : 4'h7;
  wire [15:0] bitLen = (div_r < `DIV_MIN) ? `DIV_MIN : div_r;
  wire [15:0] halfLen = {1'b0, bitLen[15:1]};

  // ==========================================
  // register bus
  assign s_axi_awready = !awHeld_r && !s_axi_bvalid;
  assign s_axi_wready  = !wHeld_r && !s_axi_bvalid;
  assign s_axi_arready = !s_axi_rvalid;
  wire doWrite = awHeld_r && wHeld_r && !s_axi_bvalid;
  wire doRead  = s_axi_arvalid && s_axi_arready;
  wire wrTxBuf = doWrite && (awAddr_r == `ADDR_TXBUF);
  wire rdRxBuf = doRead && (s_axi_araddr == `ADDR_RXBUF);
  wire rdRxErr = doRead && (s_axi_araddr == `ADDR_RXERR);
  wire txLoad  = txOn && txFull_r && (txState_r == S_IDLE);
  wire rxStore;
  wire rxOvr;
  wire [2:0] rxErrSet;

  always @(posedge clk) begin
    if (rst) begin
      awHeld_r <= 1'b0;
      wHeld_r <= 1'b0;
      awAddr_r <= 5'h00;
      wData_r <= 32'h0000_0000;
      wStrb_r <= 4'h0;
      s_axi_bvalid <= 1'b0;
      s_axi_bresp <= `RESP_OKAY;
      s_axi_rvalid <= 1'b0;
      s_axi_rresp <= `RESP_OKAY;
      s_axi_rdata <= 32'h0000_0000;
      lineModeReg_r <= `MODE_RST;
      invert_r <= 1'b0;
      div_r <= `DIV_RST;
      txBuffer_r <= 8'h00;
    end else begin
      if (s_axi_awvalid && s_axi_awready) begin
        awHeld_r <= 1'b1;
        awAddr_r <= {s_axi_awaddr[4:2], 2'b00};
      end
      if (s_axi_wvalid && s_axi_wready) begin
        wHeld_r <= 1'b1;
        wData_r <= s_axi_wdata;
        // strobes travel with the data; the master may drop them once w is taken
        wStrb_r <= s_axi_wstrb;
      end
      if (doWrite) begin
        awHeld_r <= 1'b0;
        wHeld_r <= 1'b0;
        s_axi_bvalid <= 1'b1;
        s_axi_bresp <= mapped(awAddr_r) ? `RESP_OKAY : `RESP_SLVERR;
        if (awAddr_r == `ADDR_MODE && wStrb_r[0])
          lineModeReg_r <= wData_r[7:0];
        if (awAddr_r == `ADDR_CTRL && wStrb_r[0])
          invert_r <= wData_r[`B_INVERT];
        if (awAddr_r == `ADDR_DIV) begin
          if (wStrb_r[0]) div_r[7:0] <= wData_r[7:0];
          if (wStrb_r[1]) div_r[15:8] <= wData_r[15:8];
        end
        if (awAddr_r == `ADDR_TXBUF && wStrb_r[0] && txOn)
          txBuffer_r <= wData_r[7:0];
      end else if (s_axi_bvalid && s_axi_bready) begin
        s_axi_bvalid <= 1'b0;
      end
      if (doRead) begin
        s_axi_rvalid <= 1'b1;
        s_axi_rresp <= mapped({s_axi_araddr[4:2], 2'b00}) ? `RESP_OKAY : `RESP_SLVERR;
        case ({s_axi_araddr[4:2], 2'b00})
          `ADDR_MODE:   s_axi_rdata <= {24'h00_0000, lineModeReg_r};
          `ADDR_TXBUF:  s_axi_rdata <= {24'h00_0000, txBuffer_r};
          `ADDR_RXBUF:  s_axi_rdata <= {24'h00_0000, rxBuffer_r};
          `ADDR_TXSTAT: s_axi_rdata <= {30'h0000_0000, txFull_r, txState_r != S_IDLE};
          `ADDR_RXERR:  s_axi_rdata <= {29'h0000_0000, rxErr_r};
          `ADDR_CTRL:   s_axi_rdata <= {31'h0000_0000, invert_r};
          `ADDR_DIV:    s_axi_rdata <= {16'h0000, div_r};
          default:      s_axi_rdata <= 32'h0000_0000;
        endcase
      end else if (s_axi_rvalid && s_axi_rready) begin
        s_axi_rvalid <= 1'b0;
      end
    end
  end

  // ==========================================
  // buffer and error flags; a hardware set wins over a software clear
  always @(posedge clk) begin
    if (rst || !power) begin
      txFull_r <= 1'b0;
      rxFull_r <= 1'b0;
      rxErr_r <= 3'h0;
      rxBuffer_r <= 8'h00;
    end else begin
      if (wrTxBuf && wStrb_r[0] && txOn)
        txFull_r <= 1'b1;
      else if (txLoad)
        txFull_r <= 1'b0;
      if (rxStore) begin
        rxFull_r <= 1'b1;
        rxBuffer_r <= rxShift_r;
      end else if (rdRxBuf) begin
        rxFull_r <= 1'b0;
      end
      rxErr_r <= (rdRxErr ? 3'h0 : rxErr_r) | rxErrSet;
    end
  end

  // ==========================================
  // transmitter
  always @(posedge clk) begin
    if (rst || !txOn) begin
      txState_r <= S_IDLE;
      txCnt_r <= 16'h0000;
      txBit_r <= 4'h0;
      txShift_r <= 8'h00;
      txPar_r <= 1'b0;
      txLine_r <= 1'b1;
      txIrq <= 1'b0;
    end else begin
      txIrq <= txLoad;
      case (txState_r)
        S_IDLE: begin
          txLine_r <= 1'b1;
          if (txLoad) begin
            txShift_r <= txBuffer_r;
            txPar_r <= 1'b0;
            txState_r <= S_START;
            txCnt_r <= bitLen - 16'h0001;
            txLine_r <= 1'b0;
          end
        end
        S_START, S_DATA, S_PAR: begin
          if (txCnt_r != 16'h0000) begin
            txCnt_r <= txCnt_r - 16'h0001;
          end else begin
            txCnt_r <= bitLen - 16'h0001;
            if (txState_r == S_START || (txState_r == S_DATA && txBit_r != nBits)) begin
              txState_r <= S_DATA;
              txLine_r <= txShift_r[0];
              txShift_r <= {1'b0, txShift_r[7:1]};
              // parity gathered as bits leave; the buffer may already hold the next byte
              txPar_r <= txPar_r ^ txShift_r[0];
              txBit_r <= txBit_r + 4'h1;
            end else if (txState_r == S_DATA && parMode != 2'b00) begin
              txState_r <= S_PAR;
              txLine_r <= (parMode == 2'b01) ? 1'b0 : txPar_r ^ (parMode == 2'b10);
            end else begin
              txState_r <= S_STOP;
              txBit_r <= {3'h0, lineModeReg_r[`B_STOPLEN]};
              txLine_r <= 1'b1;
            end
          end
        end
        S_STOP: begin
          if (txCnt_r != 16'h0000) begin
            txCnt_r <= txCnt_r - 16'h0001;
          end else if (txBit_r != 4'h0) begin
            txBit_r <= 4'h0;
            txCnt_r <= bitLen - 16'h0001;
          end else begin
            txIrq <= 1'b1;
            txState_r <= txFull_r ? S_GAP : S_IDLE;
            // the idle cycle that loads the next byte is the second gap clock
            txCnt_r <= {14'h0000, `TX_GAP} - 16'h0002;
          end
        end
        S_GAP: begin
          if (txCnt_r != 16'h0000)
            txCnt_r <= txCnt_r - 16'h0001;
          else
            txState_r <= S_IDLE;
        end
        default: txState_r <= S_IDLE;
      endcase
    end
  end

  // output pin is a flop, so it holds its level whenever the clock stops
  always @(posedge clk) begin
    if (rst)
      serialOutPin <= 1'b1;
    else
      serialOutPin <= (txOn ? txLine_r : 1'b1) ^ invert_r;
  end

  // ==========================================
  // receiver; samples the raw synchronised input, never the inverted sense
  always @(posedge clk) begin
    if (rst) begin
      rxSync1_r <= 1'b1;
      rxSync2_r <= 1'b1;
    end else begin
      rxSync1_r <= serialInPin;
      rxSync2_r <= rxSync1_r;
    end
  end

  wire rxMid = (rxCnt_r == 16'h0000);
  assign rxStore  = (rxState_r == S_STOP) && rxMid && !rxFull_r;
  assign rxOvr    = (rxState_r == S_STOP) && rxMid && rxFull_r;
  assign rxErrSet = {(rxState_r == S_STOP) && rxMid && rxParErr_r,
                     (rxState_r == S_STOP) && rxMid && !rxSync2_r, rxOvr};

  always @(posedge clk) begin
    if (rst || !rxOn) begin
      rxArmed_r <= 1'b0;
      rxState_r <= S_IDLE;
      rxCnt_r <= 16'h0000;
      rxBit_r <= 4'h0;
      rxShift_r <= 8'h00;
      rxParErr_r <= 1'b0;
      rxIrq <= 1'b0;
      rxErrIrq <= 1'b0;
    end else begin
      rxArmed_r <= 1'b1;
      rxIrq <= rxStore | (lineModeReg_r[`B_ROUTE] & |rxErrSet);
      rxErrIrq <= ~lineModeReg_r[`B_ROUTE] & |rxErrSet;
      case (rxState_r)
        S_IDLE: begin
          // a level test, not an edge: a line already low at enable starts a frame
          if (rxArmed_r && !rxSync2_r) begin
            rxState_r <= S_START;
            rxCnt_r <= halfLen;
          end
        end
        S_START: begin
          if (!rxMid) begin
            rxCnt_r <= rxCnt_r - 16'h0001;
          end else if (rxSync2_r) begin
            rxState_r <= S_IDLE;
          end else begin
            rxState_r <= S_DATA;
            rxBit_r <= 4'h0;
            rxParErr_r <= 1'b0;
            rxCnt_r <= bitLen - 16'h0001;
          end
        end
        S_DATA, S_PAR: begin
          if (!rxMid) begin
            rxCnt_r <= rxCnt_r - 16'h0001;
          end else begin
            rxCnt_r <= bitLen - 16'h0001;
            if (rxState_r == S_DATA) begin
              rxShift_r <= len8 ? {rxSync2_r, rxShift_r[7:1]} : {1'b0, rxSync2_r, rxShift_r[6:1]};
              rxBit_r <= rxBit_r + 4'h1;
              if (rxBit_r == nBits - 4'h1)
                rxState_r <= (parMode == 2'b00) ? S_STOP : S_PAR;
            end else begin
              rxState_r <= S_STOP;
              if (parMode[1])
                rxParErr_r <= parity(rxShift_r, len8) ^ rxSync2_r ^ ~parMode[0];
            end
          end
        end
        S_STOP: begin
          if (!rxMid)
            rxCnt_r <= rxCnt_r - 16'h0001;
          else
            rxState_r <= S_IDLE;
        end
        default: rxState_r <= S_IDLE;
      endcase
    end
  end
endmodule // async_serial_transceiver

// File: shared/uart_defs.vh
// constants for the asynchronous serial transceiver
`ifndef UART_DEFS_VH
`define UART_DEFS_VH
// ==========================================
// register byte addresses
`define ADDR_MODE     5'h00
`define ADDR_TXBUF    5'h04
`define ADDR_RXBUF    5'h08
`define ADDR_TXSTAT   5'h0C
`define ADDR_RXERR    5'h10
`define ADDR_CTRL     5'h14
`define ADDR_DIV      5'h18
// ==========================================
// line_mode_reg fields
`define B_POWER       7
`define B_TXEN        6
`define B_RXEN        5
`define B_PARHI       4
`define B_PARLO       3
`define B_CHARLEN     2
`define B_STOPLEN     1
`define B_ROUTE       0
// status and control fields
`define B_TXFULL      1
`define B_TXSHIFT     0
`define B_PERR        2
`define B_FERR        1
`define B_OVR         0
`define B_INVERT      0
// ==========================================
// reset values, timing and bus response codes
`define MODE_RST      8'h01
`define DIV_RST       16'h0010
`define DIV_MIN       16'h0004
`define TX_GAP        2'h2
`define RESP_OKAY     2'h0
`define RESP_SLVERR   2'h2
`endif

// File: sim/async_serial_transceiver_assertions.sv
// checker for the transceiver's bus handshakes and serial output
`include "uart_defs.vh"
module async_serial_transceiver_checker (
  input wire logic        clk,
  input wire logic        rst,
  input wire logic [4:0]  s_axi_awaddr,
  input wire logic        s_axi_awvalid,
  input wire logic        s_axi_awready,
  input wire logic        s_axi_wvalid,
  input wire logic        s_axi_wready,
  input wire logic [1:0]  s_axi_bresp,
  input wire logic        s_axi_bvalid,
  input wire logic        s_axi_bready,
  input wire logic [4:0]  s_axi_araddr,
  input wire logic        s_axi_arvalid,
  input wire logic        s_axi_arready,
  input wire logic [31:0] s_axi_rdata,
  input wire logic [1:0]  s_axi_rresp,
  input wire logic        s_axi_rvalid,
  input wire logic        s_axi_rready,
  input wire logic        serialOutPin
);
  timeunit 1ns;
  timeprecision 1ps;
  default clocking cb @(posedge clk); endclocking
  default disable iff (rst);
  // ==========================================
  // bus
  // both channels taken, the write lands on the next edge and the response stands after it
  a_write_answer: assert property (s_axi_awvalid && s_axi_awready && s_axi_wvalid && s_axi_wready |-> ##2 s_axi_bvalid)
    else $error("write accepted without response");
  a_write_hold: assert property (s_axi_bvalid && !s_axi_bready |=> s_axi_bvalid && $stable(s_axi_bresp))
    else $error("write response dropped early");
  a_write_block: assert property (s_axi_bvalid |-> !s_axi_awready && !s_axi_wready)
    else $error("write accepted while response pending");
  a_wr_unmapped: assert property (s_axi_awvalid && s_axi_awready && s_axi_wvalid && s_axi_wready
    && s_axi_awaddr[4:2] == 3'h7 |-> ##2 s_axi_bresp == `RESP_SLVERR)
    else $error("unmapped write not refused");
  a_read_answer: assert property (s_axi_arvalid && s_axi_arready |=> s_axi_rvalid)
    else $error("read accepted without data");
  a_read_hold: assert property (s_axi_rvalid && !s_axi_rready |=> s_axi_rvalid && $stable(s_axi_rdata))
    else $error("read data changed before taken");
  a_read_block: assert property (s_axi_rvalid |-> !s_axi_arready)
    else $error("read accepted while data pending");
  a_rd_unmapped: assert property (s_axi_arvalid && s_axi_arready && s_axi_araddr[4:2] == 3'h7
    |=> s_axi_rresp == `RESP_SLVERR && s_axi_rdata == 32'h0000_0000)
    else $error("unmapped read not refused");
  // ==========================================
  // line: the divider floor keeps every bit at least four clocks wide
  a_bit_width: assert property ($changed(serialOutPin) |=> $stable(serialOutPin) [*3])
    else $error("serial bit shorter than four clocks");
endmodule // async_serial_transceiver_checker

// File: sim/async_serial_transceiver_bench.sv
// testbench for the asynchronous serial transceiver
`include "uart_defs.vh"
module async_serial_transceiver_bench;
  timeunit 1ns;
  timeprecision 1ps;
  localparam int D = 16;
  logic        clk = 1'b0;
  logic        rst = 1'b1;
  logic [4:0]  s_axi_awaddr = 5'h00;
  logic [4:0]  s_axi_araddr = 5'h00;
  logic [31:0] s_axi_wdata = 32'h0000_0000;
  logic [3:0]  s_axi_wstrb = 4'hf;
  // answers are always accepted at the first edge they stand
  logic        s_axi_awvalid = 1'b0, s_axi_wvalid = 1'b0, s_axi_bready = 1'b1;
  logic        s_axi_arvalid = 1'b0, s_axi_rready = 1'b1;
  wire         s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid;
  wire  [1:0]  s_axi_bresp, s_axi_rresp;
  wire  [31:0] s_axi_rdata;
  wire         serialInPin, serialOutPin, txIrq, rxIrq, rxErrIrq;
  int          nFail = 0, totalChecks = 0, nErr = 0, cycles = 0, nTx = 0, nRx = 0;
  always #2.5 clk = ~clk;
  async_serial_transceiver async_serial_transceiver_inst (.clk, .rst, .s_axi_awaddr, .s_axi_awvalid,
    .s_axi_awready, .s_axi_wdata, .s_axi_wstrb, .s_axi_wvalid, .s_axi_wready, .s_axi_bresp, .s_axi_bvalid,
    .s_axi_bready, .s_axi_araddr, .s_axi_arvalid, .s_axi_arready, .s_axi_rdata, .s_axi_rresp, .s_axi_rvalid,
    .s_axi_rready, .serialInPin, .serialOutPin, .txIrq, .rxIrq, .rxErrIrq);
  remote_serial_node #(.D(D)) remote_serial_node_inst (.clk, .serialOutPin, .serialInPin);
  always @(posedge clk) begin
    cycles <= cycles + 1;
    if (rxErrIrq === 1'b1) nErr <= nErr + 1;
    if (txIrq === 1'b1) nTx <= nTx + 1;
    if (rxIrq === 1'b1) nRx <= nRx + 1;
    if (cycles == 60000) begin
      nFail++;
      testDone();
    end
  end
  // ==========================================
  // bus and checking tasks
  task automatic chk(input string n, input logic [31:0] s, input logic [31:0] e);
    totalChecks++;
    if (s !== e) begin
      nFail++;
      $display("BAD %s exp %h got %h", n, e, s);
    end
  endtask
  task automatic wr(input logic [4:0] a, input logic [7:0] d, input logic [1:0] er = `RESP_OKAY);
    logic awDone;
    logic wDone;
    awDone = 1'b0;
    wDone = 1'b0;
    s_axi_awaddr <= a;
    s_axi_wdata <= {24'h00_0000, d};
    s_axi_awvalid <= 1'b1;
    s_axi_wvalid <= 1'b1;
    while (!awDone || !wDone) begin
      @(posedge clk);
      if (s_axi_awvalid && s_axi_awready) begin
        awDone = 1'b1;
        s_axi_awvalid <= 1'b0;
      end
      if (s_axi_wvalid && s_axi_wready) begin
        wDone = 1'b1;
        s_axi_wvalid <= 1'b0;
      end
    end
    do @(posedge clk); while (!s_axi_bvalid);
    chk("bresp", s_axi_bresp, er);
  endtask
  task automatic rd(input logic [4:0] a, output logic [31:0] d, output logic [1:0] r);
    s_axi_araddr <= a;
    s_axi_arvalid <= 1'b1;
    do @(posedge clk); while (!s_axi_arready);
    s_axi_arvalid <= 1'b0;
    do @(posedge clk); while (!s_axi_rvalid);
    d = s_axi_rdata;
    r = s_axi_rresp;
  endtask
  task automatic rchk(input string n, input logic [4:0] a, input logic [31:0] e, input logic [1:0] er = 2'h0);
    logic [31:0] d;
    logic [1:0]  r;
    rd(a, d, r);
    chk(n, d, e);
    chk("rresp", r, er);
  endtask
  // ==========================================
  // scenarios
  task automatic tReset();
    rchk("mode", `ADDR_MODE, `MODE_RST);
    rchk("div", `ADDR_DIV, `DIV_RST);
    rchk("hole", 5'h1c, 32'h0000_0000, `RESP_SLVERR);
    wr(5'h1c, 8'h00, `RESP_SLVERR);
  endtask
  task automatic tTx();
    logic [31:0] v;
    logic [1:0]  r;
    wr(`ADDR_MODE, 8'h84);
    wr(`ADDR_MODE, 8'hc4);
    @(posedge clk);
    wr(`ADDR_TXBUF, 8'ha5);
    do rd(`ADDR_TXSTAT, v, r); while (v[`B_TXFULL]);
    wr(`ADDR_TXBUF, 8'h3c);
    while (remote_serial_node_inst.got.size() < 2) @(posedge clk);
    chk("tx0", remote_serial_node_inst.got[0], 8'ha5);
    chk("tx1", remote_serial_node_inst.got[1], 8'h3c);
    chk("gap", remote_serial_node_inst.fallAt[1] - remote_serial_node_inst.fallAt[0], 10 * D + 2);
    // two loads and two frame ends; the last end comes half a bit after the listener's stop sample
    repeat (D) @(posedge clk);
    chk("ntx", nTx, 4);
  endtask
  task automatic tRx();
    wr(`ADDR_MODE, 8'he4);
    wr(`ADDR_CTRL, 8'h01);
    repeat (3) @(posedge clk);
    chk("inv", serialOutPin, 1'b0);
    remote_serial_node_inst.send({1'b1, 8'h5a}, 9);
    rchk("err", `ADDR_RXERR, 32'h0000_0000);
    rchk("rx", `ADDR_RXBUF, 8'h5a);
    wr(`ADDR_CTRL, 8'h00);
  endtask
  task automatic tOvr();
    remote_serial_node_inst.send({1'b1, 8'h11}, 9);
    remote_serial_node_inst.send({1'b1, 8'h22}, 9);
    rchk("ovr", `ADDR_RXERR, 8'h01);
    rchk("keep", `ADDR_RXBUF, 8'h11);
  endtask
  task automatic tErr();
    wr(`ADDR_MODE, 8'h84);
    wr(`ADDR_MODE, 8'h9e);
    wr(`ADDR_MODE, 8'hbe);
    remote_serial_node_inst.send({1'b1, ~^8'h0f, 8'h0f}, 10);
    rchk("par", `ADDR_RXERR, 8'h04);
    rchk("pdat", `ADDR_RXBUF, 8'h0f);
    remote_serial_node_inst.send({1'b0, ^8'h0f, 8'h0f}, 10);
    rchk("frm", `ADDR_RXERR, 8'h02);
    rchk("fdat", `ADDR_RXBUF, 8'h0f);
    chk("nerr", nErr, 3);
    chk("nrx", nRx, 4);
  endtask
  task automatic testDone();
    if (nFail == 0 && totalChecks > 0) $display("ALL TESTS PASSED");
    else $display("TESTS FAILED");
    $finish;
  endtask
  initial begin
    repeat (5) @(posedge clk);
    rst <= 1'b0;
    @(posedge clk);
    tReset();
    tTx();
    tRx();
    tOvr();
    tErr();
    testDone();
  end
endmodule // async_serial_transceiver_bench
bind async_serial_transceiver async_serial_transceiver_checker async_serial_transceiver_checker_inst (.clk, .rst,
  .s_axi_awaddr, .s_axi_awvalid, .s_axi_awready, .s_axi_wvalid, .s_axi_wready, .s_axi_bresp, .s_axi_bvalid,
  .s_axi_bready, .s_axi_araddr, .s_axi_arvalid, .s_axi_arready, .s_axi_rdata, .s_axi_rresp, .s_axi_rvalid,
  .s_axi_rready, .serialOutPin);

// File: sim/remote_serial_node.sv
// remote serial node: frame sender and byte listener
module remote_serial_node #(
  parameter int D = 16
) (
  input  wire logic clk,
  input  wire logic serialOutPin,
  output logic      serialInPin
);
  timeunit 1ns;
  timeprecision 1ps;
  logic [7:0] got[$];
  int         fallAt[$];
  int         cyc = 0;
  initial serialInPin = 1'b1;
  // counted off the falling edge so a recorded fall never races the count
  always @(negedge clk) cyc <= cyc + 1;
  // ==========================================
  // sender: bits go LSB first; a low last bit is cut short so no false start follows
  task automatic send(input logic [9:0] bits, input int nb);
    serialInPin <= 1'b0;
    repeat (D) @(posedge clk);
    for (int i = 0; i < nb; i++) begin
      serialInPin <= bits[i];
      repeat ((i == nb - 1 && !bits[i]) ? D * 5 / 8 : D) @(posedge clk);
    end
    serialInPin <= 1'b1;
    repeat (2 * D) @(posedge clk);
  endtask
  // ==========================================
  // listener: only frames with a high stop bit are kept
  always begin : listen
    logic [7:0] b;
    int         t;
    @(negedge serialOutPin);
    t = cyc;
    repeat (D / 2) @(posedge clk);
    for (int i = 0; i < 8; i++) begin
      repeat (D) @(posedge clk);
      b[i] = serialOutPin;
    end
    repeat (D) @(posedge clk);
    if (serialOutPin) begin
      got.push_back(b);
      fallAt.push_back(t);
    end
  end
endmodule // remote_serial_node
